// file: hdl/adc_ctl_pkg.sv
// Shared constants, types and carriers of the converter sequencer and comparators
`default_nettype none
package adc_ctl_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_SEQ = 4;
   localparam int NUM_STEPS = 17;
   localparam int NUM_CMP = 8;
   localparam int RES_W = 12;
   localparam int CHAN_W = 5;
   localparam int ACC_W = 18;
   localparam int NUM_STATUS = 12;
   // Channel codes 0..23 are external inputs, this one is the temperature sensor
   localparam logic [4:0] CHAN_TEMP = 5'h18;
   // First flat step index and step count of each sequencer
   localparam logic [3:0][4:0] SEQ_BASE = {5'h10, 5'h0C, 5'h08, 5'h00};
   localparam logic [3:0][3:0] SEQ_DEPTH = {4'h1, 4'h4, 4'h4, 4'h8};
   // Averaging code n takes 2**n samples, codes 7 and above take 64 (AVG_MAX); 0 is off
   localparam logic [2:0] AVG_MAX = 3'h6;
   localparam logic [6:0] AVG_ONE = 7'h01;
   // Mode code fields
   localparam int MODE_ONCE_BIT = 2;
   localparam int MODE_HYST_BIT = 3;
   localparam logic [11:0] STATUS_RESET = 12'h000;

   // ==========================================================
   // Enumerations
   typedef enum logic [1:0] {
      TRIG_NEVER = 2'h0,
      TRIG_PROC = 2'h1,
      TRIG_EXT = 2'h2,
      TRIG_ALWAYS = 2'h3
   } trig_src_t;

   typedef enum logic [1:0] {
      BAND_NONE = 2'h0,
      BAND_LOW = 2'h1,
      BAND_MID = 2'h2,
      BAND_HIGH = 2'h3
   } band_t;

   // Bits [1:0] band, [2] once, [3] hysteresis
   typedef enum logic [3:0] {
      fault_trig_off = 4'h0,
      fault_trig_low_level = 4'h1,
      fault_trig_mid_level = 4'h2,
      fault_trig_high_level = 4'h3,
      fault_trig_low_entry = 4'h5,
      fault_trig_mid_entry = 4'h6,
      fault_trig_high_entry = 4'h7,
      fault_trig_low_level_hyst = 4'h9,
      fault_trig_high_level_hyst = 4'hB,
      fault_trig_low_entry_hyst = 4'hD,
      fault_trig_high_entry_hyst = 4'hF
   } cmp_mode_t;

   // Interrupt path uses the same codes
   localparam cmp_mode_t cmp_irq_low_level_hyst = fault_trig_low_level_hyst;
   localparam cmp_mode_t cmp_irq_low_entry_hyst = fault_trig_low_entry_hyst;
   localparam cmp_mode_t cmp_irq_high_level_hyst = fault_trig_high_level_hyst;
   localparam cmp_mode_t cmp_irq_high_entry_hyst = fault_trig_high_entry_hyst;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_CONV = 3'h2,
      S_DONE = 3'h4
   } seq_state_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [4:0] chan;
      logic last;
      logic cmp_en;
      logic [2:0] cmp_sel;
   } step_cfg_t;

   typedef struct packed {
      logic [11:0] low;
      logic [11:0] high;
      cmp_mode_t trig_mode;
      cmp_mode_t irq_mode;
   } cmp_cfg_t;

   typedef struct packed {
      logic [1:0] seq;
      logic [2:0] step;
      logic [4:0] chan;
      logic [11:0] data;
   } result_t;
endpackage
`default_nettype wire

// file: hdl/adc_dcmp.sv
// One digital comparator with separate fault-trigger and interrupt paths
`default_nettype none
module adc_dcmp (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Result stream
   input wire logic res_valid,
   input wire logic [11:0] res_data,
   // Configuration
   input wire adc_ctl_pkg::cmp_cfg_t cfg,
   input wire logic clr_trig,
   input wire logic clr_irq,
   // Outputs
   output logic fault_trig,
   output logic irq_evt
);
   // ==========================================================
   // Band classification
   adc_ctl_pkg::band_t band;
   logic [1:0] lvl;
   logic [1:0] evt;

   always_comb begin
      if (res_data <= cfg.low) begin
         band = adc_ctl_pkg::BAND_LOW;
      end else if (res_data <= cfg.high) begin
         band = adc_ctl_pkg::BAND_MID;
      end else begin
         band = adc_ctl_pkg::BAND_HIGH;
      end
   end

   // ==========================================================
   // Path 0 drives the fault trigger, path 1 the interrupt
   for (genvar p = 0; p < 2; p++) begin : g_path
      adc_ctl_pkg::cmp_mode_t mode;
      adc_ctl_pkg::band_t tgt;
      adc_ctl_pkg::band_t prev_q;
      logic clr;
      logic armed_q;
      logic out_q;
      logic fire_q;
      logic fire;

      assign mode = (p == 0) ? cfg.trig_mode : cfg.irq_mode;
      assign clr = (p == 0) ? clr_trig : clr_irq;
      assign tgt = adc_ctl_pkg::band_t'(mode[1:0]);
      // Level, entry and hysteresis qualifiers
      assign fire = res_valid && (mode != adc_ctl_pkg::fault_trig_off) && (band == tgt)
         && (!mode[adc_ctl_pkg::MODE_ONCE_BIT] || (prev_q != band))
         && (!mode[adc_ctl_pkg::MODE_HYST_BIT] || armed_q);

      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            prev_q <= adc_ctl_pkg::BAND_NONE;
            armed_q <= 1'b0;
            out_q <= 1'b0;
            fire_q <= 1'b0;
         end else if (clk_en) begin
            if (clr) begin
               prev_q <= adc_ctl_pkg::BAND_NONE;
               armed_q <= 1'b0;
               out_q <= 1'b0;
               fire_q <= 1'b0;
            end else begin
               fire_q <= fire;
               if (res_valid) begin
                  prev_q <= band;
                  out_q <= fire;
                  if (fire) begin
                     armed_q <= 1'b0;
                  end else if (band == ((tgt == adc_ctl_pkg::BAND_LOW) ?
                        adc_ctl_pkg::BAND_HIGH : adc_ctl_pkg::BAND_LOW)) begin
                     armed_q <= 1'b1;
                  end
               end else if (mode[adc_ctl_pkg::MODE_ONCE_BIT]) begin
                  out_q <= 1'b0;
               end
            end
         end
      end

      assign lvl[p] = out_q;
      assign evt[p] = fire_q;
   end

   assign fault_trig = lvl[0];
   assign irq_evt = evt[1];

   // ==========================================================
   // Checks
   a_low_level_trig: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && !clr_trig && res_valid && res_data <= cfg.low
       && cfg.trig_mode == adc_ctl_pkg::fault_trig_low_level) |=> fault_trig)
      else $error("low band level trigger not raised");

   a_once_pulse: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && !res_valid && cfg.trig_mode[adc_ctl_pkg::MODE_ONCE_BIT]) |=> !fault_trig)
      else $error("once trigger held past one cycle");

   a_irq_clear: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && clr_irq) |=> !irq_evt)
      else $error("interrupt event after interrupt state reset");
endmodule
`default_nettype wire

// file: hdl/adc_seq_ctl.sv
// Sample sequencer control, averaging, comparator bank and comparator interrupt status
`default_nettype none
module adc_seq_ctl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Sequencer configuration
   input wire logic [3:0] seq_en,
   input wire adc_ctl_pkg::trig_src_t [3:0] trig_src,
   input wire logic [3:0][1:0] seq_prio,
   input wire adc_ctl_pkg::step_cfg_t [16:0] step_cfg,
   input wire logic [2:0] avg_code,
   // Trigger events
   input wire logic [3:0] proc_trig,
   input wire logic ext_trig_pin,
   // Conversion core
   output logic conv_req,
   output logic [4:0] conv_chan,
   input wire logic conv_done,
   input wire logic [11:0] conv_data,
   // Results and status
   output logic res_valid,
   output adc_ctl_pkg::result_t res,
   output logic busy,
   // Comparators
   input wire adc_ctl_pkg::cmp_cfg_t [7:0] cmp_cfg,
   input wire logic [7:0] cmp_clr_trig,
   input wire logic [7:0] cmp_clr_irq,
   output logic [7:0] fault_trig,
   // Comparator interrupt status
   input wire logic status_clr_wr,
   input wire logic [11:0] status_clr_mask,
   input wire logic [3:0] seq_irq_en,
   output logic [11:0] cmp_status,
   output logic cmp_irq
);
   // ==========================================================
   // External trigger synchroniser and edge
   logic [2:0] ext_sync_q;
   logic ext_edge;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_sync_q <= 3'h0;
      end else if (clk_en) begin
         ext_sync_q <= {ext_sync_q[1:0], ext_trig_pin};
      end
   end

   assign ext_edge = ext_sync_q[1] & ~ext_sync_q[2];

   // ==========================================================
   // Trigger capture and arbitration
   adc_ctl_pkg::seq_state_t state_q;
   logic [3:0] pend_q;
   logic [3:0] trig_hit;
   logic found;
   logic [1:0] sel_seq;
   logic start;

   always_comb begin
      for (int i = 0; i < adc_ctl_pkg::NUM_SEQ; i++) begin
         trig_hit[i] = seq_en[i] && (
            (trig_src[i] == adc_ctl_pkg::TRIG_PROC && proc_trig[i]) ||
            (trig_src[i] == adc_ctl_pkg::TRIG_EXT && ext_edge) ||
            (trig_src[i] == adc_ctl_pkg::TRIG_ALWAYS));
      end
   end

   always_comb begin
      found = 1'b0;
      sel_seq = 2'h0;
      for (int i = 0; i < adc_ctl_pkg::NUM_SEQ; i++) begin
         if (pend_q[i] && (!found || seq_prio[i] < seq_prio[sel_seq])) begin
            found = 1'b1;
            sel_seq = 2'(i);
         end
      end
   end

   assign start = (state_q == adc_ctl_pkg::S_IDLE) && found;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_q <= 4'h0;
      end else if (clk_en) begin
         for (int i = 0; i < adc_ctl_pkg::NUM_SEQ; i++) begin
            pend_q[i] <= seq_en[i] &&
               ((pend_q[i] && !(start && sel_seq == 2'(i))) || trig_hit[i]);
         end
      end
   end

   // ==========================================================
   // Step sequencing and averaging
   logic [1:0] cur_seq_q;
   logic [2:0] step_q;
   logic [6:0] avg_cnt_q;
   logic [17:0] acc_q;
   logic [2:0] avg_eff;
   logic [6:0] avg_need;
   logic [4:0] idx;
   adc_ctl_pkg::step_cfg_t cur_step;
   logic seq_last;

   assign avg_eff = (avg_code > adc_ctl_pkg::AVG_MAX) ? adc_ctl_pkg::AVG_MAX : avg_code;
   assign avg_need = adc_ctl_pkg::AVG_ONE << avg_eff;
   assign idx = adc_ctl_pkg::SEQ_BASE[cur_seq_q] + {2'h0, step_q};
   assign cur_step = step_cfg[idx];
   assign seq_last = cur_step.last ||
      ({1'b0, step_q} == adc_ctl_pkg::SEQ_DEPTH[cur_seq_q] - 4'h1);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= adc_ctl_pkg::S_IDLE;
         cur_seq_q <= 2'h0;
         step_q <= 3'h0;
         avg_cnt_q <= 7'h00;
         acc_q <= 18'h00000;
         conv_chan <= 5'h00;
      end else if (clk_en) begin
         case (state_q)
            adc_ctl_pkg::S_IDLE: begin
               if (start) begin
                  cur_seq_q <= sel_seq;
                  step_q <= 3'h0;
                  avg_cnt_q <= 7'h00;
                  acc_q <= 18'h00000;
                  conv_chan <= step_cfg[adc_ctl_pkg::SEQ_BASE[sel_seq]].chan;
                  state_q <= adc_ctl_pkg::S_CONV;
               end
            end
            adc_ctl_pkg::S_CONV: begin
               if (conv_done) begin
                  acc_q <= acc_q + {6'h00, conv_data};
                  if (avg_cnt_q + 7'h01 == avg_need) begin
                     state_q <= adc_ctl_pkg::S_DONE;
                  end else begin
                     avg_cnt_q <= avg_cnt_q + 7'h01;
                  end
               end
            end
            adc_ctl_pkg::S_DONE: begin
               if (seq_last) begin
                  state_q <= adc_ctl_pkg::S_IDLE;
               end else begin
                  step_q <= step_q + 3'h1;
                  avg_cnt_q <= 7'h00;
                  acc_q <= 18'h00000;
                  conv_chan <= step_cfg[idx + 5'h01].chan;
                  state_q <= adc_ctl_pkg::S_CONV;
               end
            end
            default: begin
               state_q <= adc_ctl_pkg::S_IDLE;
            end
         endcase
      end
   end

   assign conv_req = (state_q == adc_ctl_pkg::S_CONV);
   assign busy = (state_q != adc_ctl_pkg::S_IDLE) || (|pend_q);

   // ==========================================================
   // Result register
   logic res_cmp_en_q;
   logic [2:0] res_cmp_sel_q;
   logic [17:0] avg_res;

   assign avg_res = acc_q >> avg_eff;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         res_valid <= 1'b0;
         res <= '0;
         res_cmp_en_q <= 1'b0;
         res_cmp_sel_q <= 3'h0;
      end else if (clk_en) begin
         res_valid <= (state_q == adc_ctl_pkg::S_DONE);
         if (state_q == adc_ctl_pkg::S_DONE) begin
            res <= {cur_seq_q, step_q, cur_step.chan, avg_res[11:0]};
            res_cmp_en_q <= cur_step.cmp_en;
            res_cmp_sel_q <= cur_step.cmp_sel;
         end
      end
   end

   // ==========================================================
   // Comparator bank
   logic [7:0] irq_evt;

   for (genvar c = 0; c < adc_ctl_pkg::NUM_CMP; c++) begin : g_cmp
      adc_dcmp u_dcmp (
         .clk_sys(clk_sys),
         .reset(reset),
         .clk_en(clk_en),
         .res_valid(res_valid && res_cmp_en_q && res_cmp_sel_q == 3'(c)),
         .res_data(res.data),
         .cfg(cmp_cfg[c]),
         .clr_trig(cmp_clr_trig[c]),
         .clr_irq(cmp_clr_irq[c]),
         .fault_trig(fault_trig[c]),
         .irq_evt(irq_evt[c])
      );
   end

   // ==========================================================
   // Comparator interrupt status: [7:0] per comparator, [11:8] per sequence
   logic [11:0] status_set;
   logic [11:0] status_clr;

   always_comb begin
      status_set = {4'h0, irq_evt};
      if (|irq_evt) begin
         status_set[4'h8 + {2'h0, res.seq}] = 1'b1;
      end
      status_clr = status_clr_wr ? status_clr_mask : 12'h000;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmp_status <= adc_ctl_pkg::STATUS_RESET;
      end else if (clk_en) begin
         cmp_status <= (cmp_status & ~status_clr) | status_set;
      end
   end

   assign cmp_irq = |(cmp_status[11:8] & seq_irq_en);

   // ==========================================================
   // Checks
   logic [6:0] conv_cnt_q;
   logic prio_ok;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         conv_cnt_q <= 7'h00;
      end else if (clk_en) begin
         if (res_valid) begin
            conv_cnt_q <= {6'h00, conv_done};
         end else if (conv_done && conv_req) begin
            conv_cnt_q <= conv_cnt_q + 7'h01;
         end
      end
   end

   always_comb begin
      prio_ok = 1'b1;
      for (int j = 0; j < adc_ctl_pkg::NUM_SEQ; j++) begin
         if (pend_q[j] && seq_prio[j] < seq_prio[sel_seq]) begin
            prio_ok = 1'b0;
         end
      end
   end

   a_avg_count: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && res_valid) |-> (conv_cnt_q == avg_need))
      else $error("result built from wrong number of samples");

   a_prio_pick: assert property (@(posedge clk_sys) disable iff (reset)
      start |-> prio_ok)
      else $error("lower priority sequencer started first");

   a_busy_start: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && start) |=> busy && conv_req)
      else $error("sequence start without busy");

   a_never_idle: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && !busy && !(|proc_trig) && !ext_edge && !(|trig_hit)) |=> !busy)
      else $error("busy without a trigger");

   a_status_sticky: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && !status_clr_wr) |=> ((cmp_status & $past(cmp_status)) == $past(cmp_status)))
      else $error("status bit lost without clear");

   a_status_clear: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && status_clr_wr && status_set == 12'h000) |=>
      ((cmp_status & $past(status_clr_mask)) == 12'h000 &&
       (cmp_status | $past(status_clr_mask)) == ($past(cmp_status) | $past(status_clr_mask))))
      else $error("clear mask did not act exactly");

   a_seq_gate: assert property (@(posedge clk_sys) disable iff (reset)
      (seq_irq_en == 4'h0) |-> !cmp_irq)
      else $error("interrupt passed a disabled sequence");
endmodule
`default_nettype wire

// file: testbench/conv_core_model.sv
// Behavioural conversion core that answers conversion requests of the sequencer
`default_nettype none
module conv_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Request side
   input wire logic conv_req,
   input wire logic [4:0] conv_chan,
   // Answer side
   output logic conv_done,
   output logic [11:0] conv_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Timing: three cycles per sample, sample index counts within one request
   logic wait_q;
   logic [5:0] cnt_q;
   logic [11:0] val;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wait_q <= 1'b0;
         cnt_q <= 6'h00;
         conv_done <= 1'b0;
      end else if (!conv_req) begin
         wait_q <= 1'b0;
         cnt_q <= 6'h00;
         conv_done <= 1'b0;
      end else if (conv_done) begin
         conv_done <= 1'b0;
         cnt_q <= cnt_q + 6'h01;
      end else begin
         wait_q <= !wait_q;
         conv_done <= wait_q;
      end
   end
   // Sample value is channel * 128 plus sample index; inverted outside the strobe
   assign val = {conv_chan, 7'h00} + {6'h00, cnt_q};
   assign conv_data = conv_done ? val : ~val;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench of the sequencer control and comparator bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, reset, clk_en, ext_trig_pin, conv_req, conv_done, res_valid, busy;
   logic status_clr_wr, cmp_irq;
   logic [3:0] seq_en, proc_trig, seq_irq_en;
   adc_ctl_pkg::trig_src_t [3:0] trig_src;
   logic [3:0][1:0] seq_prio;
   adc_ctl_pkg::step_cfg_t [16:0] step_cfg;
   logic [2:0] avg_code;
   logic [4:0] conv_chan;
   logic [11:0] conv_data, status_clr_mask, cmp_status;
   adc_ctl_pkg::result_t res;
   adc_ctl_pkg::cmp_cfg_t [7:0] cmp_cfg;
   logic [7:0] cmp_clr_trig, cmp_clr_irq, fault_trig;
   int fail_count, n_checks;

   adc_seq_ctl dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .seq_en(seq_en),
      .trig_src(trig_src), .seq_prio(seq_prio), .step_cfg(step_cfg), .avg_code(avg_code),
      .proc_trig(proc_trig), .ext_trig_pin(ext_trig_pin), .conv_req(conv_req),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
      .res_valid(res_valid), .res(res), .busy(busy), .cmp_cfg(cmp_cfg),
      .cmp_clr_trig(cmp_clr_trig), .cmp_clr_irq(cmp_clr_irq), .fault_trig(fault_trig),
      .status_clr_wr(status_clr_wr), .status_clr_mask(status_clr_mask),
      .seq_irq_en(seq_irq_en), .cmp_status(cmp_status), .cmp_irq(cmp_irq));
   conv_core_model core (.clk_sys(clk_sys), .reset(reset), .conv_req(conv_req),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data));

   always #50 clk_sys = ~clk_sys;

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_sys) proc_trig <= m;
      @(posedge clk_sys) proc_trig <= 4'h0;
   endtask
   task automatic wait_res();
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (res_valid !== 1'b1 && n < 300);
      if (n >= 300) check(32'h0, 32'h1);
   endtask
   task automatic set_modes(input adc_ctl_pkg::cmp_mode_t t, input adc_ctl_pkg::cmp_mode_t q);
      @(posedge clk_sys);
      cmp_cfg[0].trig_mode <= t;
      cmp_cfg[0].irq_mode <= q;
   endtask
   task automatic clr(input logic t, input logic q);
      @(posedge clk_sys);
      cmp_clr_trig <= {7'h00, t};
      cmp_clr_irq <= {7'h00, q};
      @(posedge clk_sys);
      cmp_clr_trig <= 8'h00;
      cmp_clr_irq <= 8'h00;
   endtask
   task automatic clr_status(input logic [11:0] m);
      @(posedge clk_sys);
      status_clr_wr <= 1'b1;
      status_clr_mask <= m;
      @(posedge clk_sys) status_clr_wr <= 1'b0;
      @(negedge clk_sys);
   endtask
   // One result of the single-step sequencer on comparator 0; fault output one cycle later
   task automatic run3(input logic [4:0] ch, output logic ft);
      @(posedge clk_sys) step_cfg[16] <= '{chan: ch, last: 1'b1, cmp_en: 1'b1, cmp_sel: 3'h0};
      pulse(4'h8);
      wait_res();
      @(negedge clk_sys) ft = fault_trig[0];
      @(negedge clk_sys);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_depth();
      int cnt;
      pulse(4'h1);
      for (int i = 0; i < 8; i++) begin
         wait_res();
         if (i == 0) check(busy, 1);
         check(res.seq, 0);
         check(res.step, i);
         check(res.chan, i);
         check(res.data, i * 128);
      end
      cnt = 0;
      repeat (20) begin
         @(negedge clk_sys);
         if (res_valid !== 1'b0) cnt++;
      end
      check(cnt, 0);
      check(busy, 0);
      $display("test depth done");
   endtask
   task automatic t_prio();
      @(posedge clk_sys) avg_code <= 3'h2;
      pulse(4'h6);
      wait_res();
      check(res.seq, 2);
      check(res.data, 12'h281);
      wait_res();
      check(res.seq, 1);
      check(res.data, 12'h181);
      @(posedge clk_sys) avg_code <= 3'h0;
      $display("test priority done");
   endtask
   task automatic t_level();
      logic ft;
      set_modes(adc_ctl_pkg::fault_trig_mid_level, adc_ctl_pkg::fault_trig_off);
      run3(5'h17, ft);
      check(ft, 1);
      run3(5'h00, ft);
      check(ft, 0);
      set_modes(adc_ctl_pkg::fault_trig_high_level, adc_ctl_pkg::fault_trig_off);
      run3(5'h18, ft);
      check(ft, 1);
      set_modes(adc_ctl_pkg::fault_trig_low_level, adc_ctl_pkg::fault_trig_off);
      run3(5'h00, ft);
      check(ft, 1);
      check(fault_trig[7:1], 7'h00);
      $display("test level done");
   endtask
   task automatic t_once();
      logic ft;
      set_modes(adc_ctl_pkg::fault_trig_mid_entry, adc_ctl_pkg::fault_trig_off);
      run3(5'h17, ft);
      check(ft, 1);
      run3(5'h17, ft);
      check(ft, 0);
      set_modes(adc_ctl_pkg::fault_trig_high_entry, adc_ctl_pkg::fault_trig_off);
      run3(5'h18, ft);
      check(ft, 1);
      $display("test once done");
   endtask
   task automatic t_hyst();
      logic ft;
      set_modes(adc_ctl_pkg::fault_trig_high_level_hyst, adc_ctl_pkg::fault_trig_off);
      clr(1'b1, 1'b0);
      run3(5'h18, ft);
      check(ft, 0);
      run3(5'h00, ft);
      check(ft, 0);
      run3(5'h18, ft);
      check(ft, 1);
      $display("test hysteresis done");
   endtask
   task automatic t_status();
      logic ft;
      set_modes(adc_ctl_pkg::fault_trig_off, adc_ctl_pkg::cmp_irq_low_entry_hyst);
      clr(1'b0, 1'b1);
      clr_status(12'hFFF);
      run3(5'h00, ft);
      check(cmp_status[0], 0);
      run3(5'h18, ft);
      run3(5'h00, ft);
      check(cmp_status[0], 1);
      set_modes(adc_ctl_pkg::fault_trig_off, adc_ctl_pkg::fault_trig_mid_level);
      clr_status(12'hFFF);
      run3(5'h17, ft);
      check(cmp_status, 12'h801);
      check(cmp_irq, 0);
      @(posedge clk_sys) seq_irq_en <= 4'h8;
      @(negedge clk_sys) check(cmp_irq, 1);
      clr_status(12'h001);
      check(cmp_status, 12'h800);
      $display("test status done");
   endtask
   task automatic t_ext();
      int cnt;
      @(posedge clk_sys) trig_src[3] <= adc_ctl_pkg::TRIG_EXT;
      @(posedge clk_sys) ext_trig_pin <= 1'b1;
      wait_res();
      check(res.seq, 3);
      cnt = 0;
      // A pin held high is one edge, so exactly one run
      repeat (20) begin
         @(negedge clk_sys);
         if (res_valid !== 1'b0) cnt++;
      end
      check(cnt, 0);
      @(posedge clk_sys) ext_trig_pin <= 1'b0;
      trig_src[3] <= adc_ctl_pkg::TRIG_ALWAYS;
      wait_res();
      wait_res();
      check(res.seq, 3);
      @(posedge clk_sys) trig_src[3] <= adc_ctl_pkg::TRIG_NEVER;
      cnt = 0;
      do begin
         @(negedge clk_sys);
         cnt++;
      end while (busy !== 1'b0 && cnt < 50);
      check(busy, 0);
      $display("test external done");
   endtask
   task automatic t_idle();
      int cnt;
      @(posedge clk_sys);
      for (int i = 0; i < 4; i++) trig_src[i] <= adc_ctl_pkg::TRIG_NEVER;
      pulse(4'hF);
      cnt = 0;
      repeat (20) begin
         @(negedge clk_sys);
         if (res_valid !== 1'b0) cnt++;
      end
      check(cnt, 0);
      check(busy, 0);
      $display("test idle done");
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      ext_trig_pin = 1'b0;
      seq_en = 4'hF;
      proc_trig = 4'h0;
      seq_irq_en = 4'h0;
      avg_code = 3'h0;
      status_clr_wr = 1'b0;
      status_clr_mask = 12'h000;
      cmp_clr_trig = 8'h00;
      cmp_clr_irq = 8'h00;
      seq_prio = {2'h3, 2'h0, 2'h1, 2'h2};
      for (int i = 0; i < 4; i++) trig_src[i] = adc_ctl_pkg::TRIG_PROC;
      for (int i = 0; i < 17; i++) begin
         step_cfg[i] = '{chan: 5'(i), last: 1'b0, cmp_en: 1'b0, cmp_sel: 3'h0};
      end
      step_cfg[8] = '{chan: 5'h03, last: 1'b1, cmp_en: 1'b0, cmp_sel: 3'h0};
      step_cfg[12] = '{chan: 5'h05, last: 1'b1, cmp_en: 1'b0, cmp_sel: 3'h0};
      for (int i = 0; i < 8; i++) begin
         cmp_cfg[i] = '{low: 12'h000, high: 12'hBFF, trig_mode: adc_ctl_pkg::fault_trig_off,
            irq_mode: adc_ctl_pkg::fault_trig_off};
      end
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      t_depth();
      t_prio();
      t_level();
      t_once();
      t_hyst();
      t_status();
      t_ext();
      t_idle();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
